// File: logic/sst_pkg.sv
// Purpose: Constants and types for the speed switch threshold registers
// Assumes: 8-bit register port, 7-bit address, one 100 MHz clock
// Notes: Offsets without a printed value are placed in free slots
package sst_pkg;
   // ******************************
   // Register offsets
   // ******************************
   localparam logic [6:0] ADDR_STEP4_UP = 7'h6a;
   localparam logic [6:0] ADDR_STEP5_DN = 7'h6b;
   localparam logic [6:0] ADDR_AD_CTRL = 7'h6d;
   localparam logic [6:0] ADDR_FAST_ATH = 7'h6e;
   localparam logic [6:0] ADDR_FAST_DTH = 7'h6f;
   localparam logic [6:0] ADDR_SLOW_ATH = 7'h70;
   localparam logic [6:0] ADDR_SLOW_DTH = 7'h71;
   localparam logic [6:0] ADDR_SPEED_CFG = 7'h63;
   // ******************************
   // Reset values
   // ******************************
   localparam logic [7:0] RST_STEP4_UP = 8'h50;
   localparam logic [7:0] RST_STEP5_DN = 8'h48;
   localparam logic [7:0] RST_AD_CTRL = 8'hc4;
   localparam logic [7:0] RST_FAST_ATH = 8'h34;
   localparam logic [7:0] RST_FAST_DTH = 8'h20;
   localparam logic [7:0] RST_SLOW_ATH = 8'h20;
   localparam logic [7:0] RST_SLOW_DTH = 8'h34;
   localparam logic [7:0] RST_SPEED_CFG = 8'h04;
   // ******************************
   // Fields
   // ******************************
   localparam int STEP_LSB = 0;
   localparam int CFG_HI_BIT = 0;
   localparam int CFG_LO_BIT = 1;
   localparam int CFG_IVAL_LSB = 2;
   localparam logic [2:0] STEP_MIN = 3'h1;
   localparam logic [2:0] STEP_MAX = 3'h5;
   localparam logic [2:0] STEP_RESET = 3'h4;
   // ******************************
   // Resolutions and timing
   // ******************************
   typedef enum logic [2:0] {
      SST_CPI_250 = 3'h0, SST_CPI_500 = 3'h1, SST_CPI_750 = 3'h2,
      SST_CPI_1000 = 3'h3, SST_CPI_1250 = 3'h4
   } sst_cpi_t;
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int IVAL_BASE_MS = 4;
   // Register port carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } sst_req_t;
endpackage

// File: logic/sst_regs.sv
// Purpose: Speed switch threshold registers and resolution step control
// Assumes: Host port requests synchronous to clk_i; velocity given in ips*8
// Notes: Check interval counts 1 ms ticks; tick count is a parameter
`timescale 1ns/1ps
module sst_regs #(
   parameter int TICK_CYCLES = sst_pkg::TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire sst_pkg::sst_req_t req_i,
   input wire logic [7:0] velocity_i,
   input wire logic [7:0] shutter_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic [2:0] step_o,
   output sst_pkg::sst_cpi_t cpi_o,
   output logic fast_o,
   output logic slow_o
);
   // Elaboration check on tick length
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
   end

   // ******************************
   // Register file
   // ******************************
   localparam int NREG = 8;
   localparam logic [6:0] ADDRS [NREG] = '{
      sst_pkg::ADDR_STEP4_UP, sst_pkg::ADDR_STEP5_DN, sst_pkg::ADDR_AD_CTRL,
      sst_pkg::ADDR_FAST_ATH, sst_pkg::ADDR_FAST_DTH, sst_pkg::ADDR_SLOW_ATH,
      sst_pkg::ADDR_SLOW_DTH, sst_pkg::ADDR_SPEED_CFG};
   localparam logic [7:0] RSTS [NREG] = '{
      sst_pkg::RST_STEP4_UP, sst_pkg::RST_STEP5_DN, sst_pkg::RST_AD_CTRL,
      sst_pkg::RST_FAST_ATH, sst_pkg::RST_FAST_DTH, sst_pkg::RST_SLOW_ATH,
      sst_pkg::RST_SLOW_DTH, sst_pkg::RST_SPEED_CFG};
   logic [7:0] regs_reg [NREG];
   logic [7:0] regs_next [NREG];
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;

   // Address hit decode, shared by read and write paths
   function automatic logic hit(input logic [6:0] a, input int idx);
      hit = (a == ADDRS[idx]);
   endfunction

   // Writes store whole bytes; bits 7:6 of control kept as written
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         regs_next[i] = regs_reg[i];
         if (req_i.wr && hit(req_i.addr, i)) begin
            regs_next[i] = req_i.wdata;
         end
      end
   end

   // Readback, unmapped offsets read as zero
   always_comb begin
      rdata_next = 8'h00;
      rvalid_next = req_i.rd;
      for (int i = 0; i < NREG; i++) begin
         if (req_i.rd && hit(req_i.addr, i)) begin
            rdata_next = regs_reg[i];
         end
      end
   end

   generate
      for (genvar g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               regs_reg[g] <= RSTS[g];
            end else begin
               regs_reg[g] <= regs_next[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ******************************
   // Field views
   // ******************************
   logic [7:0] up_th, dn_th, cfg;
   logic [7:0] fast_assert_level, fast_deassert_level;
   logic [7:0] slow_assert_level, slow_deassert_level;
   logic [2:0] top_step_select;
   logic [1:0] switch_check_interval;
   logic highest_resolution_enable, lowest_resolution_enable;
   assign up_th = regs_reg[0];
   assign dn_th = regs_reg[1];
   assign fast_assert_level = regs_reg[3];
   assign fast_deassert_level = regs_reg[4];
   assign slow_assert_level = regs_reg[5];
   assign slow_deassert_level = regs_reg[6];
   assign cfg = regs_reg[7];
   // Bits 7:6 are host duty; hardware ignores them
   assign top_step_select = regs_reg[2][sst_pkg::STEP_LSB +: 3];
   assign switch_check_interval = cfg[sst_pkg::CFG_IVAL_LSB +: 2];
   assign highest_resolution_enable = cfg[sst_pkg::CFG_HI_BIT];
   assign lowest_resolution_enable = cfg[sst_pkg::CFG_LO_BIT];

   // ******************************
   // Check interval timer
   // ******************************
   logic [31:0] tick_cnt_reg, tick_cnt_next;
   logic [4:0] ms_cnt_reg, ms_cnt_next;
   logic check_reg, check_next;
   logic [4:0] ms_target;

   // Interval of (field+1)*4 ms; 4 ms floor avoids step chatter
   always_comb begin
      ms_target = 5'((32'(switch_check_interval) + 32'd1) * sst_pkg::IVAL_BASE_MS);
      tick_cnt_next = tick_cnt_reg + 32'd1;
      ms_cnt_next = ms_cnt_reg;
      check_next = 1'b0;
      if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt_next = 32'd0;
         ms_cnt_next = ms_cnt_reg + 5'd1;
         if (ms_cnt_reg + 5'd1 >= ms_target) begin
            ms_cnt_next = 5'd0;
            check_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_reg <= 32'd0;
         ms_cnt_reg <= 5'd0;
         check_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         ms_cnt_reg <= ms_cnt_next;
         check_reg <= check_next;
      end
   end

   // ******************************
   // Step control and shutter levels
   // ******************************
   logic [2:0] step_reg, step_next;
   logic [2:0] ceil_step;
   logic fast_reg, fast_next, slow_reg, slow_next;
   sst_pkg::sst_cpi_t cpi_reg, cpi_next;

   // Step walks within 1..top select; only steps 4/5 thresholds held here
   always_comb begin
      ceil_step = (top_step_select < sst_pkg::STEP_MIN) ? sst_pkg::STEP_MIN :
                  (top_step_select > sst_pkg::STEP_MAX) ? sst_pkg::STEP_MAX :
                  top_step_select;
      step_next = step_reg;
      if (step_reg > ceil_step) begin
         step_next = ceil_step;
      end else if (check_reg) begin
         if (velocity_i > up_th && step_reg < ceil_step) begin
            step_next = step_reg + 3'd1;
         end else if (velocity_i < dn_th && step_reg > sst_pkg::STEP_MIN) begin
            step_next = step_reg - 3'd1;
         end
      end
      case (step_next)
         3'h1: cpi_next = lowest_resolution_enable ? sst_pkg::SST_CPI_250
                          : sst_pkg::SST_CPI_500;
         3'h2: cpi_next = sst_pkg::SST_CPI_500;
         3'h3: cpi_next = sst_pkg::SST_CPI_750;
         3'h5: cpi_next = highest_resolution_enable ? sst_pkg::SST_CPI_1250
                          : sst_pkg::SST_CPI_1000;
         default: cpi_next = sst_pkg::SST_CPI_1000;
      endcase
      // Hysteresis pairs: fast asserts above, releases below; slow asserts below, releases above
      fast_next = fast_reg;
      if (shutter_i >= fast_assert_level) begin
         fast_next = 1'b1;
      end else if (shutter_i < fast_deassert_level) begin
         fast_next = 1'b0;
      end
      slow_next = slow_reg;
      if (shutter_i <= slow_assert_level) begin
         slow_next = 1'b1;
      end else if (shutter_i > slow_deassert_level) begin
         slow_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         step_reg <= sst_pkg::STEP_RESET;
         cpi_reg <= sst_pkg::SST_CPI_1000;
         fast_reg <= 1'b0;
         slow_reg <= 1'b0;
      end else begin
         step_reg <= step_next;
         cpi_reg <= cpi_next;
         fast_reg <= fast_next;
         slow_reg <= slow_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign rvalid_o = rvalid_reg;
   assign step_o = step_reg;
   assign cpi_o = cpi_reg;
   assign fast_o = fast_reg;
   assign slow_o = slow_reg;
endmodule

// File: test/sst_host.sv
// Purpose: Host model that issues register requests
// Assumes: Requests change 1 ns after the rising edge
// Notes: A request stands until the next one or idle
`timescale 1ns/1ps
module sst_host (
   input wire logic clk_i,
   output sst_pkg::sst_req_t req_o
);
   initial req_o = '0;
   // Held across the taking edge, so back to back needs no gap
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      req_o = {w, !w, a, d};
      @(posedge clk_i);
      #1;
   endtask
   // Control writes always carry ones in the top two bits
   task automatic ctl(input logic [2:0] s);
      acc(1'b1, sst_pkg::ADDR_AD_CTRL, {2'b11, 3'h0, s});
   endtask
   task automatic idle();
      req_o = '0;
      @(posedge clk_i);
      #1;
   endtask
endmodule

// File: test/sst_regs_checker.sv
// Purpose: Port checks for the speed switch registers
// Assumes: One clock, reset high
// Notes: Thresholds are inside, so flag levels are left to the bench
`timescale 1ns/1ps
module sst_regs_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire sst_pkg::sst_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [2:0] step_o,
   input wire sst_pkg::sst_cpi_t cpi_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_read_answer: assert property (req_i.rd |=> rvalid_o)
      else $error("read got no answer");
   a_idle_quiet: assert property (!req_i.rd |=> !rvalid_o && rdata_o == 8'h00)
      else $error("answer without a read");
   a_step_range: assert property (step_o inside {[3'h1:3'h5]})
      else $error("step out of range");
   a_reset_step: assert property ($fell(rst_i) |-> step_o == 3'h4)
      else $error("step not 4 after reset");
   a_low_step: assert property (step_o == 3'h1 |->
      cpi_o inside {sst_pkg::SST_CPI_250, sst_pkg::SST_CPI_500})
      else $error("lowest step resolution wrong");
   a_top_step: assert property (step_o == 3'h5 |->
      cpi_o inside {sst_pkg::SST_CPI_1000, sst_pkg::SST_CPI_1250})
      else $error("highest step resolution wrong");
   a_mid_step: assert property (step_o == 3'h4 |-> cpi_o == sst_pkg::SST_CPI_1000)
      else $error("step 4 resolution wrong");
   a_up_by_one: assert property (step_o > $past(step_o) |-> step_o == $past(step_o) + 3'h1)
      else $error("step jumped up");
   // Up moves only at check pulses, never two in a row
   a_up_spaced: assert property (step_o > $past(step_o) |=> (step_o <= $past(step_o))[*8])
      else $error("up moves too close");
   // Middle steps have one fixed resolution each
   a_step2_cpi: assert property (step_o == 3'h2 |-> cpi_o == sst_pkg::SST_CPI_500)
      else $error("step 2 resolution wrong");
   a_step3_cpi: assert property (step_o == 3'h3 |-> cpi_o == sst_pkg::SST_CPI_750)
      else $error("step 3 resolution wrong");
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench for the speed switch registers
// Assumes: TICK_CYCLES of 10, so 1 ms is 10 cycles
// Notes: Reads are noted in a queue and matched by a monitor
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   sst_pkg::sst_req_t req_i;
   logic [7:0] velocity_i = 8'h00;
   logic [7:0] shutter_i = 8'h00;
   logic [7:0] rdata_o;
   logic rvalid_o, fast_o, slow_o;
   logic [2:0] step_o;
   sst_pkg::sst_cpi_t cpi_o;
   logic [31:0] lf = 32'hfa2289c3;
   logic [7:0] q[$];
   logic [6:0] ad[6] = '{7'h6a, 7'h6b, 7'h6e, 7'h6f, 7'h70, 7'h71};
   logic [7:0] sh[4] = '{8'h90, 8'h50, 8'h10, 8'h50};
   int n_fail = 0;
   int num_checks = 0;
   time t0;
   always #5 clk_i = ~clk_i;
   sst_host i_host (.clk_i(clk_i), .req_o(req_i));
   sst_regs #(.TICK_CYCLES(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
      .velocity_i(velocity_i), .shutter_i(shutter_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .step_o(step_o), .cpi_o(cpi_o), .fast_o(fast_o), .slow_o(slow_o));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      q.push_back(e);
      i_host.acc(1'b0, a, 8'h00);
   endtask
   // Poll with a bound so a stuck step cannot hang the run
   task automatic wait_step(input logic [2:0] s, input int lim);
      int n = 0;
      while (step_o !== s && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk({5'h0, step_o}, {5'h0, s});
   endtask
   // Cycles between two step moves at the current check interval
   task automatic gap(input logic [2:0] a, input logic [2:0] b, input int cyc);
      time t;
      wait_step(a, 200);
      t = $time;
      wait_step(b, 200);
      chk(8'(($time - t) / 10), 8'(cyc));
   endtask
   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Each read answer takes the oldest note; mid-cycle, where it is settled
   always @(negedge clk_i) begin
      if (rvalid_o === 1'b1) begin
         if (q.size() == 0)
            chk(8'h01, 8'h00);
         else
            chk(rdata_o, q.pop_front());
      end
   end
   initial begin
      #50000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      #1 rst_i = 0;
      rd(sst_pkg::ADDR_STEP5_DN, 8'h48);
      rd(sst_pkg::ADDR_FAST_ATH, 8'h34);
      rd(sst_pkg::ADDR_AD_CTRL, sst_pkg::RST_AD_CTRL);
      rd(sst_pkg::ADDR_SPEED_CFG, sst_pkg::RST_SPEED_CFG);
      rd(7'h72, 8'h00);
      $display("reset test done");
      // Random bytes, written and read back to back
      foreach (ad[i]) begin
         lf = lfsr(lf);
         i_host.acc(1'b1, ad[i], lf[7:0]);
         rd(ad[i], lf[7:0]);
      end
      $display("random test done");
      // Hysteresis of 80 keeps each flag in the middle band
      i_host.acc(1'b1, sst_pkg::ADDR_FAST_ATH, 8'h80);
      i_host.acc(1'b1, sst_pkg::ADDR_FAST_DTH, 8'h30);
      i_host.acc(1'b1, sst_pkg::ADDR_SLOW_ATH, 8'h20);
      i_host.acc(1'b1, sst_pkg::ADDR_SLOW_DTH, 8'h70);
      i_host.idle();
      foreach (sh[i]) begin
         shutter_i = sh[i];
         repeat (3) @(posedge clk_i);
         #1;
         chk({7'h0, fast_o}, {7'h0, i < 2});
         chk({7'h0, slow_o}, {7'h0, i > 1});
      end
      $display("flag test done");
      // Both enables on, 4 ms checks
      i_host.acc(1'b1, sst_pkg::ADDR_STEP4_UP, 8'h50);
      i_host.acc(1'b1, sst_pkg::ADDR_STEP5_DN, 8'h48);
      i_host.acc(1'b1, sst_pkg::ADDR_SPEED_CFG, 8'h03);
      i_host.ctl(3'h5);
      i_host.idle();
      velocity_i = 8'hff;
      wait_step(3'h5, 200);
      chk({5'h0, cpi_o}, 8'h04);
      velocity_i = 8'h00;
      wait_step(3'h4, 60);
      t0 = $time;
      wait_step(3'h3, 60);
      chk(8'(($time - t0) / 10), 8'd40);
      wait_step(3'h1, 100);
      chk({5'h0, cpi_o}, 8'h00);
      i_host.acc(1'b1, sst_pkg::ADDR_SPEED_CFG, 8'h01);
      i_host.ctl(3'h2);
      i_host.idle();
      chk({5'h0, cpi_o}, 8'h01);
      // Top select of 2 caps the climb
      velocity_i = 8'hff;
      wait_step(3'h2, 60);
      repeat (100) @(posedge clk_i);
      #1;
      chk({5'h0, step_o}, 8'h02);
      $display("step test done");
      // Longer intervals: 16 ms while climbing, 12 ms while falling
      i_host.acc(1'b1, sst_pkg::ADDR_SPEED_CFG, 8'h0d);
      i_host.ctl(3'h5);
      i_host.idle();
      gap(3'h3, 3'h4, 160);
      velocity_i = 8'h00;
      i_host.acc(1'b1, sst_pkg::ADDR_SPEED_CFG, 8'h09);
      i_host.idle();
      gap(3'h3, 3'h2, 120);
      // Every noted read must have been answered
      chk(8'(q.size()), 8'h00);
      $display("interval test done");
      report_and_stop();
   end
endmodule
bind sst_regs sst_regs_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
   .rdata_o(rdata_o), .rvalid_o(rvalid_o), .step_o(step_o), .cpi_o(cpi_o));
